// >>> rtl/emi_core.sv
// Purpose: external memory interface muxing core buses onto one bus
// Assumes: a machine cycle is two clk periods, phase enable from a divider
// Notes:   core holds its requests until the matching done pulse
// Operation
// [RULE1] separate 64K program, data, io spaces
// [RULE2] on-chip hits stay off the bus
// [RULE3] upper 32K data local or global
// [RULE4] global access drives request from start
// [RULE5] order: write, data read, fetch
// [RULE6] 16-bit address and data bus
// [RULE7] exactly one space select per cycle
// [RULE8] external data space limited to 32K
// [RULE9] io uses same bus protocol
// [RULE10] read/write indicator per cycle
// [RULE11] strobe marks every external cycle
// [RULE12] ready low stalls the cycle
// [RULE13] outside logic drives ready high
// [RULE14] arbiter asserts ready after global access
// [RULE15] zero-wait reads, two-cycle writes
// [RULE16] write data drive delayed half cycle
// [RULE17] whole-cycle waits, ready unlimited
// [RULE18] release request when cycle completes
// [RULE19] wait count and ready both needed
`timescale 1ns/1ns
`default_nettype none
module emi_core
  import emi_pkg::*;
#(
  parameter int unsigned WAIT_WIDTH = emi_pkg::WAIT_W
) (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire emi_pkg::emi_req_t           prog_req,
  input  wire emi_pkg::emi_req_t           rd_req,
  input  wire emi_pkg::emi_req_t           wr_req,
  input  wire logic                        prog_onchip,
  input  wire logic                        rd_onchip,
  input  wire logic                        wr_onchip,
  input  wire logic [7:0]                  global_map_register,
  input  wire logic [WAIT_WIDTH-1:0]       wait_count,
  input  wire logic                        ready,
  input  wire logic [emi_pkg::DATA_W-1:0]  data_in,
  output logic [emi_pkg::ADDR_W-1:0]       addr_out,
  output logic [emi_pkg::DATA_W-1:0]       data_out,
  output logic                             data_oe,
  output logic                             program_space_select_b,
  output logic                             data_space_select_b,
  output logic                             io_space_select_b,
  output logic                             rd_nwr,
  output logic                             cycle_timing_strobe_b,
  output logic                             global_access_request_b,
  output logic                             prog_done,
  output logic                             rd_done,
  output logic                             wr_done,
  output logic [emi_pkg::DATA_W-1:0]       rd_data
);
  import emi_pkg::*;

  emi_state_t           st_q, st_d;
  logic                 phase_q;
  emi_req_t             cur_q;
  logic [1:0]           src_q;
  logic                 wr_second_q;
  logic                 glob_q;
  logic [ADDR_W-1:0]    addr_q;
  logic [DATA_W-1:0]    dout_q, rdat_q;
  logic                 oe_q, ps_q, ds_q, is_q, rnw_q, cycle_timing_strobe_q, br_q;
  logic                 pd_q, rd_q, wd_q;

  // phase enable: second half of each machine cycle
  wire cyc_end = phase_q;

  // [RULE2] on-chip filter
  wire wr_ext = wr_req.valid && !wr_onchip;
  wire rd_ext = rd_req.valid && !rd_onchip;
  wire pf_ext = prog_req.valid && !prog_onchip;

  // [RULE5] priority pick
  wire       pick_any = wr_ext || rd_ext || pf_ext;
  wire [1:0] pick_src = wr_ext ? 2'h2 : (rd_ext ? 2'h1 : 2'h0);
  wire emi_req_t pick_req = wr_ext ? wr_req : (rd_ext ? rd_req : prog_req);

  // [RULE3] global map for upper half of data space
  wire pick_glob = (pick_req.space == EMI_SPACE_DATA) && pick_req.addr[GLOBAL_BIT]
                   && (global_map_register != GMAP_RESET);

  logic wait_exp;
  wire  start = (st_q == EMI_IDLE) && pick_any && !phase_q;

  emi_wait_gen #(.WIDTH(WAIT_WIDTH)) u_wait (
    .clk     (clk),
    .rst_b   (rst_b),
    .load    (start),
    .count   (wait_count),
    .tick    (cyc_end),
    .expired (wait_exp)
  );

  // [RULE12] [RULE17] [RULE19] cycle ends on ready and expired count
  wire may_end = ready && wait_exp && cyc_end;

  // [RULE15] writes take two machine cycles
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      EMI_IDLE:  if (start) st_d = EMI_ADDR;
      EMI_ADDR:  if (cyc_end) st_d = cur_q.write ? EMI_WRDRV : EMI_WAIT;
      EMI_WRDRV: begin
        if (may_end) st_d = EMI_DONE;
        else if (cyc_end) st_d = EMI_WAIT;
      end
      EMI_WAIT:  if (may_end || (cur_q.write && !wr_second_q && cyc_end && ready && wait_exp))
                   st_d = EMI_DONE;
      EMI_DONE:  st_d = EMI_IDLE;
      default:   st_d = EMI_IDLE;
    endcase
  end

  // reads end in the first machine cycle when ready and no waits
  wire read_fast = (st_q == EMI_ADDR) && !cur_q.write && ready && wait_exp && cyc_end;
  wire in_cycle  = (st_q != EMI_IDLE) && (st_q != EMI_DONE);
  // [RULE15] a write may close at the end of its second machine cycle
  wire slow_end  = (st_q == EMI_WRDRV) || (st_q == EMI_WAIT);
  wire finish    = read_fast || (slow_end && st_d == EMI_DONE);
  // the bus stays claimed up to the edge that finishes the cycle
  wire hold_bus  = in_cycle && !finish;

  // [RULE1] [RULE7] exactly one space select per cycle
  wire new_prog  = start && (pick_req.space == EMI_SPACE_PROG);
  wire new_data  = start && (pick_req.space == EMI_SPACE_DATA);
  wire new_io    = start && (pick_req.space == EMI_SPACE_IO);
  wire cur_prog  = hold_bus && (cur_q.space == EMI_SPACE_PROG);
  wire cur_data  = hold_bus && (cur_q.space == EMI_SPACE_DATA);
  wire cur_io    = hold_bus && (cur_q.space == EMI_SPACE_IO);
  // [RULE4] [RULE18] request rises with the address, drops at completion
  wire br_on     = (start && pick_glob) || (hold_bus && glob_q);
  // [RULE11] strobe covers the same edges as the select
  wire cycle_timing_strobe_on   = start || hold_bus;
  // [RULE16] write drive starts half a machine cycle after the address
  wire oe_on     = cur_q.write && !finish &&
                   ((st_q == EMI_ADDR && cyc_end) ||
                    (st_q == EMI_WRDRV) ||
                    (st_q == EMI_WAIT));
  // [RULE8] local data addresses folded into the lower 32K
  wire fold_addr = (pick_req.space == EMI_SPACE_DATA) && !pick_glob;
  wire [ADDR_W-1:0] addr_d = fold_addr ? {1'b0, pick_req.addr[ADDR_W-2:0]} : pick_req.addr;
  // one done pulse for the unit whose request just completed
  wire done_prog = finish && (src_q == 2'h0);
  wire done_rd   = finish && (src_q == 2'h1);
  wire done_wr   = finish && (src_q == 2'h2);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q        <= EMI_IDLE;
      phase_q     <= 1'b0;
      cur_q       <= '0;
      src_q       <= 2'h0;
      wr_second_q <= 1'b0;
      glob_q      <= 1'b0;
    end else begin
      phase_q <= !phase_q;
      st_q    <= read_fast ? EMI_DONE : st_d;
      if (start) begin
        cur_q  <= pick_req;
        src_q  <= pick_src;
        glob_q <= pick_glob;
      end
      wr_second_q <= (st_q == EMI_WRDRV);
    end
  end

  // pin registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q <= '0;
      dout_q <= '0;
      oe_q   <= 1'b0;
      ps_q   <= 1'b1;
      ds_q   <= 1'b1;
      is_q   <= 1'b1;
      rnw_q  <= 1'b1;
      cycle_timing_strobe_q <= 1'b1;
      br_q   <= 1'b1;
      rdat_q <= '0;
      pd_q   <= 1'b0;
      rd_q   <= 1'b0;
      wd_q   <= 1'b0;
    end else begin
      // [RULE6] [RULE9] [RULE10] shared bus, direction set per cycle
      if (start) begin
        addr_q <= addr_d;
        dout_q <= pick_req.wdata;
        rnw_q  <= !pick_req.write;
      end
      ps_q   <= !(new_prog || cur_prog);
      ds_q   <= !(new_data || cur_data);
      is_q   <= !(new_io || cur_io);
      br_q   <= !br_on;
      cycle_timing_strobe_q <= !cycle_timing_strobe_on;
      oe_q   <= oe_on;
      // [RULE13] [RULE14] read data taken at the finishing edge
      if (finish && !cur_q.write) rdat_q <= data_in;
      pd_q   <= done_prog;
      rd_q   <= done_rd;
      wd_q   <= done_wr;
    end
  end

  assign addr_out                = addr_q;
  assign data_out                = dout_q;
  assign data_oe                 = oe_q;
  assign program_space_select_b  = ps_q;
  assign data_space_select_b     = ds_q;
  assign io_space_select_b       = is_q;
  assign rd_nwr                  = rnw_q;
  assign cycle_timing_strobe_b   = cycle_timing_strobe_q;
  assign global_access_request_b = br_q;
  assign prog_done               = pd_q;
  assign rd_done                 = rd_q;
  assign wr_done                 = wd_q;
  assign rd_data                 = rdat_q;
endmodule : emi_core
`default_nettype wire

// >>> include/emi_pkg.sv
// Purpose: shared constants and types of the external memory interface
// Assumes: one machine cycle is divided into two clock phases
// Notes:   address spaces are 16 bits wide
package emi_pkg;

  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned DATA_W      = 16;
  localparam int unsigned WAIT_W      = 3;
  // data space above this bit is the switchable global half
  localparam int unsigned GLOBAL_BIT  = 15;
  localparam logic [WAIT_W-1:0] WAIT_ZERO = 3'h0;
  localparam logic [7:0] GMAP_RESET   = 8'h00;

  typedef enum logic [1:0] {
    EMI_SPACE_PROG = 2'h0,
    EMI_SPACE_DATA = 2'h1,
    EMI_SPACE_IO   = 2'h2
  } emi_space_t;

  // one request from the core side
  typedef struct packed {
    logic               valid;
    logic               write;
    emi_space_t         space;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  wdata;
  } emi_req_t;

  // selected pins of one external cycle
  typedef struct packed {
    logic               prog_sel;
    logic               data_sel;
    logic               io_sel;
  } emi_sel_t;

  typedef enum logic [4:0] {
    EMI_IDLE   = 5'h01,
    EMI_ADDR   = 5'h02,
    EMI_WRDRV  = 5'h04,
    EMI_WAIT   = 5'h08,
    EMI_DONE   = 5'h10
  } emi_state_t;

endpackage : emi_pkg

// >>> rtl/emi_wait_gen.sv
// Purpose: software wait-state counter for one external cycle
// Assumes: load pulses at cycle start, tick once per machine cycle
// Notes:   expired stays high until the next load
`timescale 1ns/1ns
`default_nettype none
module emi_wait_gen #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] count,
  input  wire logic             tick,
  output var  logic             expired
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  assign cnt_d   = load ? count : ((tick && cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
  assign expired = (cnt_q == '0) && !load;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : emi_wait_gen
`default_nettype wire

// >>> verification/emi_core_asserts.sv
// Purpose: port checks of the external memory interface
// Assumes: selects, strobe and request are active low
// Notes:   bound from the bench
`timescale 1ns/1ns
`default_nettype none
module emi_core_asserts (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [15:0] addr_out,
  input wire logic        data_oe,
  input wire logic        program_space_select_b,
  input wire logic        data_space_select_b,
  input wire logic        io_space_select_b,
  input wire logic        rd_nwr,
  input wire logic        cycle_timing_strobe_b,
  input wire logic        global_access_request_b,
  input wire logic        prog_done,
  input wire logic        rd_done,
  input wire logic        wr_done
);
  wire s_b = cycle_timing_strobe_b;
  wire d_b = data_space_select_b;
  wire g_b = global_access_request_b;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_sel; !s_b |-> $countones({program_space_select_b, d_b, io_space_select_b}) == 2;
  endproperty
  a_sel: assert property (p_sel) else $error("select count");
  property p_stb; s_b == &{program_space_select_b, d_b, io_space_select_b};
  endproperty
  a_stb: assert property (p_stb) else $error("strobe apart from select");
  property p_rw; !s_b && !$past(s_b) |-> $stable(rd_nwr);
  endproperty
  a_rw: assert property (p_rw) else $error("direction moved");
  property p_oe; data_oe |-> !rd_nwr && !$past(rd_nwr);
  endproperty
  a_oe: assert property (p_oe) else $error("drive not delayed");
  property p_brs; $fell(g_b) |-> $fell(d_b);
  endproperty
  a_brs: assert property (p_brs) else $error("request late");
  property p_brh; !g_b |-> !d_b;
  endproperty
  a_brh: assert property (p_brh) else $error("request held");
  property p_lim; !d_b && g_b |-> !addr_out[15];
  endproperty
  a_lim: assert property (p_lim) else $error("local above 32K");
  property p_wr; $fell(s_b) && !rd_nwr |-> !wr_done [*3];
  endproperty
  a_wr: assert property (p_wr) else $error("short write");
  property p_one; $onehot0({prog_done, rd_done, wr_done});
  endproperty
  a_one: assert property (p_one) else $error("two dones");
endmodule : emi_core_asserts
`default_nettype wire

// >>> verification/emi_mem_model.sv
// Purpose: external memory and arbiter model
// Assumes: ready follows a programmable delay
// Notes:   released bus toggles every cycle
`timescale 1ns/1ns
`default_nettype none
module emi_mem_model (
  input  wire logic        clk,
  input  wire logic [3:0]  slow,
  input  wire logic [15:0] addr_out,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe,
  input  wire logic        program_space_select_b,
  input  wire logic        data_space_select_b,
  input  wire logic        io_space_select_b,
  input  wire logic        rd_nwr,
  input  wire logic        cycle_timing_strobe_b,
  input  wire logic        global_access_request_b,
  output var  logic        ready,
  output var  logic [15:0] data_in
);
  logic [15:0] mem [64] = '{default: 16'h0000};
  logic [15:0] tg = 16'hA5C3;
  logic [4:0]  cnt = 5'h00;
  wire  [5:0]  ix = {!io_space_select_b, !data_space_select_b, addr_out[3:0]};
  wire         sel = !(program_space_select_b & data_space_select_b & io_space_select_b);
  // ready held low for the set delay, two clocks longer while the global request is low
  assign ready = cnt >= ({1'b0, slow} + (global_access_request_b ? 5'h00 : 5'h02));
  assign data_in = (sel && rd_nwr) ? mem[ix] : tg;
  always_ff @(posedge clk) begin
    tg  <= ~tg;
    cnt <= cycle_timing_strobe_b ? 5'h00 : cnt + {4'h0, cnt != 5'h1F};
    if (!cycle_timing_strobe_b && data_oe && !rd_nwr) mem[ix] <= data_out;
  end
endmodule : emi_mem_model
`default_nettype wire

// >>> verification/emi_core_bench.sv
// Purpose: self-checking bench of the external memory interface
// Assumes: partner model answers with a set ready delay
// Notes:   fixed seed, random values among corner cases
`timescale 1ns/1ns
`default_nettype none
module emi_core_bench;
  import emi_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        onc = 1'b0;
  logic [7:0]  global_map_register = 8'h00;
  logic [2:0]  wait_count = 3'h0;
  logic [3:0]  slow = 4'h0;
  emi_req_t    rq [3] = '{default: '0};
  int          num_errors = 0;
  int          tests_run = 0;
  int          nbr = 0;
  int          nst = 0;
  logic [15:0] q, a, d;
  logic [11:0] ord;
  wire         data_oe, rd_nwr, prog_done, rd_done, wr_done, ready;
  wire         program_space_select_b, data_space_select_b, io_space_select_b;
  wire         cycle_timing_strobe_b, global_access_request_b;
  wire  [15:0] addr_out, data_out, data_in, rd_data;
  wire  [2:0]  dn = {wr_done, rd_done, prog_done};
  emi_core DUT (.clk, .rst_b, .prog_req(rq[0]), .rd_req(rq[1]), .wr_req(rq[2]),
    .prog_onchip(onc), .rd_onchip(onc), .wr_onchip(onc), .global_map_register, .wait_count,
    .ready, .data_in, .addr_out, .data_out, .data_oe, .program_space_select_b,
    .data_space_select_b, .io_space_select_b, .rd_nwr, .cycle_timing_strobe_b,
    .global_access_request_b, .prog_done, .rd_done, .wr_done, .rd_data);
  emi_mem_model u_mem (.clk, .slow, .addr_out, .data_out, .data_oe, .program_space_select_b,
    .data_space_select_b, .io_space_select_b, .rd_nwr, .cycle_timing_strobe_b,
    .global_access_request_b, .ready, .data_in);
  always #2 clk = ~clk;
  always @(posedge clk) begin
    nbr += int'(!global_access_request_b);
    nst += int'(!cycle_timing_strobe_b);
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test
  task automatic wait_done(input logic [2:0] m, output int n);
    n = 0;
    while ((dn & m) === 3'h0) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 500) begin
        num_errors++;
        end_of_test();
      end
    end
  endtask : wait_done
  task automatic op(input int i, input emi_space_t s, input logic [15:0] ad, output int n);
    rq[i] = '{1'b1, i == 2, s, ad, d};
    wait_done(3'h1 << i, n);
    q = rd_data;
    rq[i].valid = 1'b0;
    @(posedge clk);
    #1;
  endtask : op
  // lower bound in clocks for a ready delay and a wait count
  function automatic int lb(input int s, input int w);
    return (s > 2 * w) ? s : 2 * w;
  endfunction : lb
  initial begin
    int n, m;
    void'($urandom(32'hD309B995));
    repeat (10) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (6) begin
      a = 16'($urandom) & 16'h7FFF;
      for (int s = 0; s < 3; s++) begin
        d = a ^ 16'(s * 16'h1111);
        op(2, emi_space_t'(s), a, n);
      end
      for (int s = 0; s < 3; s++) begin
        op(s == 0 ? 0 : 1, emi_space_t'(s), a, m);
        chk(q, a ^ 16'(s * 16'h1111));
      end
      chk(16'(n > m), 16'h1);
    end
    $display("write-back done");
    ord = 12'h000;
    rq[0] = '{1'b1, 1'b0, EMI_SPACE_PROG, 16'h0003, d};
    rq[1] = '{1'b1, 1'b0, EMI_SPACE_IO, 16'h0004, d};
    rq[2] = '{1'b1, 1'b1, EMI_SPACE_DATA, 16'h0005, d};
    for (int k = 0; k < 3; k++) begin
      wait_done(3'h7, n);
      ord = {ord[7:0], 4'(dn[2] ? 2 : (dn[1] ? 1 : 0))};
      rq[dn[2] ? 2 : (dn[1] ? 1 : 0)].valid = 1'b0;
      @(posedge clk);
      #1;
    end
    chk(16'(ord), 16'h0210);
    onc = 1'b1;
    nst = 0;
    rq[1] = '{1'b1, 1'b0, EMI_SPACE_DATA, 16'h0009, d};
    repeat (20) @(posedge clk);
    #1;
    rq[1].valid = 1'b0;
    onc = 1'b0;
    chk(16'(nst), 16'h0000);
    for (int g = 0; g < 2; g++) begin
      global_map_register = g ? 8'($urandom_range(255, 1)) : 8'h00;
      nbr = 0;
      op(1, EMI_SPACE_DATA, 16'h8001, n);
      chk(16'(nbr > 0), 16'(g));
    end
    $display("order, on-chip and global done");
    repeat (8) begin
      slow = 4'($urandom % 8);
      wait_count = 3'($urandom);
      op(1, EMI_SPACE_IO, 16'h0002, n);
      chk(16'(n >= lb(slow, wait_count)), 16'h0001);
      chk(16'(n <= lb(slow, wait_count) + 4), 16'h0001);
    end
    $display("wait states done");
    end_of_test();
  end
endmodule : emi_core_bench
bind emi_core emi_core_asserts u_chk (.clk, .rst_b, .addr_out, .data_oe,
  .program_space_select_b, .data_space_select_b, .io_space_select_b, .rd_nwr,
  .cycle_timing_strobe_b, .global_access_request_b, .prog_done, .rd_done, .wr_done);
`default_nettype wire
